/* File: hdl/vfd_driver.sv */
// Purpose: serial-in latched 33-output display driver with dimming
// Assumes: all pins asynchronous to clk_sys, serial clock well below clk_sys/4
// Notes:   latched words pass a two-entry buffer; latchHold stalls the latch
`timescale 1ns/1ps
module vfd_driver (
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    input  wire logic                serialClk,
    input  wire logic                serialDataIn,
    input  wire logic                loadStrobe,
    input  wire logic                dataOutPinIn,
    output logic                     dataOutPinOut,
    output logic                     dataOutPinOe_n,
    input  wire logic                blankPinIn,
    output logic                     blankPinOut,
    output logic                     blankPinOe_n,
    input  wire logic                dimSourceSelect,
    input  wire vfd_pkg::vfd_step_t  dimLevelVoltage,
    input  wire logic                factoryTestSelA,
    input  wire logic                factoryTestSelB,
    input  wire logic                rcOscillatorPin,
    input  wire logic                latchHold,
    output vfd_pkg::vfd_latch_t      drvOut,
    output logic                     loadBusy
);
    import vfd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        vfd_pins_t  sync1;
        vfd_pins_t  sync2;
        logic       sclkPrev;
        logic       loadPrev;
        logic       oscPrev;
        logic       oscTick;
        vfd_word_t  shifter;
        logic       loadPend;
        vfd_latch_t latched;
        vfd_latch_t drv;
        vfd_drive_t dataPin;
        vfd_drive_t blankPin;
    } drv_state_t;

    drv_state_t st_r;
    drv_state_t st_nxt;
    vfd_pins_t  pinsNow;
    logic       bufInReady;
    logic       bufOutValid;
    logic       bufOutReady;
    vfd_latch_t bufOutData;
    logic       pushOk;
    logic       pwmOn;

    // ------------------------------------------------------------
    // routing of latched bits to driver outputs
    // ------------------------------------------------------------
    // latch bit k holds shifter bit k+1; shifter bit 0 reaches no output
    function automatic vfd_latch_t route(input vfd_latch_t l);
        vfd_latch_t r;
        r = LATCH_RESET;
        for (int n = 0; n < NUM_OUT; n++)
        begin
            r[n] = l[OUT_BIT[n] - 6'h01];   // RULE12 RULE13 RULE14
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // pin bundle
    // ------------------------------------------------------------
    always_comb
    begin
        pinsNow.sclk   = serialClk;
        pinsNow.sdin   = serialDataIn;
        pinsNow.load   = loadStrobe;
        pinsNow.doIn   = dataOutPinIn;
        pinsNow.blank  = blankPinIn;
        pinsNow.dimSel = dimSourceSelect;
        pinsNow.testA  = factoryTestSelA;
        pinsNow.testB  = factoryTestSelB;
        pinsNow.osc    = rcOscillatorPin;
        pinsNow.step   = dimLevelVoltage;
    end

    assign pushOk      = st_r.loadPend && bufInReady;
    assign bufOutReady = !latchHold;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic testMode;
        logic sclkRise;
        logic loadRise;
        logic serialBit;
        logic wave;
        testMode  = st_r.sync2.testA || st_r.sync2.testB;
        sclkRise  = st_r.sync2.sclk && !st_r.sclkPrev;
        loadRise  = st_r.sync2.load && !st_r.loadPrev;
        // in test mode the serial output pin feeds the shifter
        serialBit = testMode ? st_r.sync2.doIn : st_r.sync2.sdin;   // RULE6
        // steady high blank gives full duty
        wave      = st_r.sync2.dimSel ? pwmOn : st_r.sync2.blank;   // RULE8 RULE21
        st_nxt = st_r;
        // sync1 is read only by sync2
        st_nxt.sync1 = pinsNow;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sclkPrev = st_r.sync2.sclk;
        st_nxt.loadPrev = st_r.sync2.load;
        st_nxt.oscPrev  = st_r.sync2.osc;
        st_nxt.oscTick  = st_r.sync2.osc && !st_r.oscPrev;

        // shift only while strobe low and no load is waiting
        if (sclkRise && !st_r.sync2.load && !st_r.loadPend)          // RULE1 RULE20
        begin
            // new bit enters at the top, first bit ends at 0
            st_nxt.shifter = {serialBit, st_r.shifter[SHIFT_W-1:1]}; // RULE2 RULE19
        end

        // accepted word clears the shifter
        if (pushOk)
        begin
            st_nxt.shifter  = SHIFT_CLEAR;                           // RULE1
            st_nxt.loadPend = 1'b0;
        end
        // a new strobe edge wins over the clear
        if (loadRise)
        begin
            st_nxt.loadPend = 1'b1;                                  // RULE1 RULE5
        end

        if (bufOutValid && bufOutReady)
        begin
            st_nxt.latched = bufOutData;
        end

        // serial output carries bit 0, the bit leaving the shifter
        st_nxt.dataPin.out  = st_nxt.shifter[0];                     // RULE4 RULE5
        st_nxt.dataPin.oe_n = testMode;                              // RULE6

        st_nxt.blankPin.out  = pwmOn;                                // RULE9
        st_nxt.blankPin.oe_n = !(st_r.sync2.dimSel || testMode);     // RULE8 RULE9 RULE10

        st_nxt.drv = route(st_r.latched) & {NUM_OUT{wave}};          // RULE3 RULE22 RULE11
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
            st_r.dataPin.oe_n  <= 1'b0;
            st_r.blankPin.oe_n <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // word buffer and dimming generator
    // ------------------------------------------------------------
    vfd_word_buf #(
        .W     (NUM_OUT),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .inValid  (st_r.loadPend),
        .inReady  (bufInReady),
        .inData   (st_r.shifter[SHIFT_W-1:1]),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    vfd_pwm u_pwm (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .oscTick (st_r.oscTick),
        .step    (st_r.sync2.step),
        .pwmOn   (pwmOn)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign drvOut         = st_r.drv;
    assign dataOutPinOut  = st_r.dataPin.out;
    assign dataOutPinOe_n = st_r.dataPin.oe_n;
    assign blankPinOut    = st_r.blankPin.out;
    assign blankPinOe_n   = st_r.blankPin.oe_n;
    assign loadBusy       = st_r.loadPend;

endmodule

/* File: hdl/vfd_pkg.sv */
// Purpose: shared constants and types for the serial display driver
// Assumes: clk_sys at 10 MHz, every pin sampled by clk_sys
// Notes:   routing table maps each driver output to a latched shifter bit
//
// Functional notes
// RULE1 - strobe low shifts; rising strobe latches, clears shifter
// RULE2 - data sampled on serial clock rising edge
// RULE3 - latched one turns output on, zero off
// RULE4 - serial output presents data leaving the shifter
// RULE5 - serial output tied to strobe gives auto-load
// RULE6 - test mode turns serial output pin into input
// RULE7 - host keeps test selects inactive normally
// RULE8 - select low: blank pin input gates outputs
// RULE9 - select high: level sets PWM, driven on pin
// RULE10 - test mode drives blank pin as output
// RULE11 - outputs 8 to 15 high current, logic same
// RULE12 - route outputs 1 to 11 per table
// RULE13 - route outputs 12 to 22 per table
// RULE14 - route outputs 23 to 33; bit 0 unused
// RULE15 - 49 steps in 2048 frame, top 208
// RULE16 - steps 1 to 12 give twelve plus step
// RULE17 - then steps of 2, 4, 8 counts
// RULE18 - auto-load word has leading one start bit
// RULE19 - first bit lands at 0, last at 33
// RULE20 - strobe high ignores data; raise during clock low
// RULE21 - constant high blank gives full duty
// RULE22 - output on only when bit and waveform high
// RULE23 - PWM counter runs from oscillator, 2048 period
package vfd_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int                SHIFT_W     = 34;
    localparam int                NUM_OUT     = 33;
    localparam int                STEP_W      = 6;
    localparam int                CNT_W       = 11;
    localparam logic [SHIFT_W-1:0] SHIFT_CLEAR = 34'h0;
    localparam logic [NUM_OUT-1:0] LATCH_RESET = 33'h0;
    localparam int                BUF_DEPTH   = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_HZ = 10000000;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // pwm duty curve
    // ------------------------------------------------------------
    localparam int               FRAME_COUNTS = 2048;
    localparam logic [STEP_W-1:0] STEP_MAX    = 6'h31;
    localparam logic [STEP_W-1:0] STEP_SEG1   = 6'h0c;
    localparam logic [STEP_W-1:0] STEP_SEG2   = 6'h18;
    localparam logic [STEP_W-1:0] STEP_SEG3   = 6'h24;
    localparam logic [STEP_W-1:0] STEP_SEG4   = 6'h30;
    localparam logic [CNT_W-1:0]  ON_SEG1_ADD = 11'h00c;
    localparam logic [CNT_W-1:0]  ON_SEG3_SUB = 11'h030;
    localparam logic [CNT_W-1:0]  ON_SEG4_SUB = 11'h0c0;
    localparam logic [CNT_W-1:0]  ON_TOP      = 11'h0d0;
    localparam logic [CNT_W-1:0]  ON_OFF      = 11'h000;

    // ------------------------------------------------------------
    // output routing: entry n is the bit feeding output n+1
    // ------------------------------------------------------------
    localparam logic [5:0] OUT_BIT [0:NUM_OUT-1] = '{
        6'h0e, 6'h0f, 6'h01, 6'h21, 6'h05, 6'h06, 6'h07, 6'h1c, 6'h1b, 6'h1f, 6'h12,
        6'h02, 6'h0a, 6'h1a, 6'h1d, 6'h08, 6'h03, 6'h09, 6'h04, 6'h0b, 6'h10, 6'h11,
        6'h0c, 6'h13, 6'h18, 6'h19, 6'h14, 6'h20, 6'h15, 6'h16, 6'h17, 6'h1e, 6'h0d
    };

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [SHIFT_W-1:0] vfd_word_t;
    typedef logic [NUM_OUT-1:0] vfd_latch_t;
    typedef logic [STEP_W-1:0]  vfd_step_t;

    typedef struct packed {
        logic      sclk;
        logic      sdin;
        logic      load;
        logic      doIn;
        logic      blank;
        logic      dimSel;
        logic      testA;
        logic      testB;
        logic      osc;
        vfd_step_t step;
    } vfd_pins_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } vfd_drive_t;

endpackage

/* File: hdl/vfd_word_buf.sv */
// Purpose: two-entry word buffer between shifter and output latch
// Assumes: single clock, both sides on clk_sys
// Notes:   inReady low when both entries hold words
`timescale 1ns/1ps
module vfd_word_buf #(
    parameter int W     = 33,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    import vfd_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           rdPtr;
        logic [PW-1:0]           wrPtr;
        logic [PW:0]             count;
    } buf_state_t;

    buf_state_t st_r;
    buf_state_t st_nxt;
    logic       push;
    logic       pop;

    assign inReady  = (st_r.count != FULL_CNT);
    assign outValid = (st_r.count != '0);
    assign outData  = st_r.mem[st_r.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wrPtr] = inData;
            st_nxt.wrPtr = (st_r.wrPtr == LAST_PTR) ? '0 : st_r.wrPtr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rdPtr = (st_r.rdPtr == LAST_PTR) ? '0 : st_r.rdPtr + 1'b1;
        end
        if (push && !pop)
        begin
            st_nxt.count = st_r.count + 1'b1;
        end
        else if (pop && !push)
        begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

/* File: hdl/vfd_pwm.sv */
// Purpose: internal dimming waveform, 2048-count frame
// Assumes: oscTick is a one-cycle pulse per oscillator period
// Notes:   step taken only at frame start so a frame never glitches
`timescale 1ns/1ps
module vfd_pwm (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             oscTick,
    input  wire vfd_pkg::vfd_step_t step,
    output logic                  pwmOn
);
    import vfd_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] onCount;
        logic             on;
    } pwm_state_t;

    pwm_state_t st_r;
    pwm_state_t st_nxt;

    // on-counts per step
    function automatic logic [CNT_W-1:0] on_count(input vfd_step_t s);
        logic [CNT_W-1:0] sx;
        sx = {{(CNT_W-STEP_W){1'b0}}, s};
        if (s == '0)
            return ON_OFF;
        else if (s <= STEP_SEG1)
            return sx + ON_SEG1_ADD;                       // RULE16
        else if (s <= STEP_SEG2)
            return {sx[CNT_W-2:0], 1'b0};                  // RULE17
        else if (s <= STEP_SEG3)
            return {sx[CNT_W-3:0], 2'b00} - ON_SEG3_SUB;   // RULE17
        else if (s <= STEP_SEG4)
            return {sx[CNT_W-4:0], 3'b000} - ON_SEG4_SUB;  // RULE17
        else
            return ON_TOP;                                 // RULE15
    endfunction

    assign pwmOn = st_r.on;

    always_comb
    begin
        st_nxt = st_r;
        if (oscTick)
        begin
            // 11-bit counter wraps every FRAME_COUNTS ticks
            st_nxt.cnt = st_r.cnt + 1'b1;                  // RULE23
            if (st_nxt.cnt == '0)
            begin
                st_nxt.onCount = on_count(step);           // RULE15
            end
            st_nxt.on = (st_nxt.cnt < st_nxt.onCount);     // RULE23
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

/* File: tb/vfd_driver_properties.sv */
// Purpose: port-level properties of the display driver
// Assumes: pins pass two sync flops and one register
// Notes:   bound to every vfd_driver instance
`timescale 1ns/1ps
module vfd_driver_properties (
    input wire logic                clk_sys,
    input wire logic                resetn,
    input wire logic                loadStrobe,
    input wire logic                dataOutPinOut,
    input wire logic                dataOutPinOe_n,
    input wire logic                blankPinIn,
    input wire logic                blankPinOut,
    input wire logic                blankPinOe_n,
    input wire logic                dimSourceSelect,
    input wire logic                factoryTestSelA,
    input wire logic                factoryTestSelB,
    input wire logic                latchHold,
    input wire vfd_pkg::vfd_latch_t drvOut,
    input wire logic                loadBusy
);
    import vfd_pkg::*;
    // ------------------------------------------------------------
    // pin modes, gating, load
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_test;
        (factoryTestSelA || factoryTestSelB)[*5];
    endsequence
    sequence s_ext_dark;
        (!dimSourceSelect && !factoryTestSelA && !factoryTestSelB && !blankPinIn)[*8];
    endsequence
    sequence s_int_dark;
        (dimSourceSelect && !factoryTestSelA && !factoryTestSelB && !blankPinOut)[*8];
    endsequence
    a_test_pin_input: assert property (s_test |-> dataOutPinOe_n)
        else $error("serial out pin driven in test mode");
    a_test_blank_drive: assert property (s_test |-> !blankPinOe_n)
        else $error("blank pin not driven in test mode");
    a_int_blank_drive: assert property (dimSourceSelect[*5] |-> !blankPinOe_n)
        else $error("blank pin not driven with internal dimming");
    a_ext_dark_off: assert property (s_ext_dark |-> drvOut == '0)
        else $error("outputs lit while blank input low");
    a_int_dark_off: assert property (s_int_dark |-> drvOut == '0)
        else $error("outputs lit while pwm low");
    a_busy_cause: assert property ($rose(loadBusy) |-> $past(loadStrobe, 2))
        else $error("load pending without strobe");
    a_busy_bounded: assert property (loadBusy && !latchHold
        |-> ##[0:12] (!loadBusy || latchHold))
        else $error("load pending too long");
    a_clear_after_load: assert property ($rose(loadBusy) && !latchHold
        |-> ##[1:6] !dataOutPinOut)
        else $error("shifter not cleared after load");
endmodule
bind vfd_driver vfd_driver_properties u_props (.clk_sys, .resetn, .loadStrobe,
    .dataOutPinOut, .dataOutPinOe_n, .blankPinIn, .blankPinOut, .blankPinOe_n,
    .dimSourceSelect, .factoryTestSelA, .factoryTestSelB, .latchHold, .drvOut, .loadBusy);

/* File: tb/vfd_host_model.sv */
// Purpose: host side of the serial link
// Assumes: called at a falling system clock edge
// Notes:   link clock 800 ns, stands low between words
`timescale 1ns/1ps
module vfd_host_model (
    output logic serialClk,
    output logic serialDataIn,
    output logic loadStrobe
);
    initial
    begin
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        loadStrobe = 1'b0;
    end
    task automatic sendWord(input logic [33:0] w);
        for (int i = 0; i < 34; i++)
        begin
            serialDataIn = w[i];
            #400 serialClk = 1'b1;
            #200 serialDataIn = ~w[i];
            #200 serialClk = 1'b0;
        end
    endtask
    // strobe moves only while the link clock is low
    task automatic holdLoad(input logic v);
        #100 loadStrobe = v;
        #1500;
    endtask
    task automatic pulseLoad;
        holdLoad(1'b1);
        holdLoad(1'b0);
    endtask
endmodule

/* File: tb/test_vfd_driver.sv */
// Purpose: self-checking bench for the serial display driver
// Assumes: host model drives the link, bench the other pins
// Notes:   oscillator 400 ns, so one frame is 8192 clocks
`timescale 1ns/1ps
module test_vfd_driver;
    import vfd_pkg::*;
    localparam int MAP [0:32] = '{14, 15, 1, 33, 5, 6, 7, 28, 27, 31, 18, 2, 10, 26, 29, 8,
        3, 9, 4, 11, 16, 17, 12, 19, 24, 25, 20, 32, 21, 22, 23, 30, 13};
    localparam int STEPS [0:4] = '{1, 12, 24, 36, 49};
    localparam vfd_word_t W1 = 34'h2a5c396f1;
    localparam vfd_word_t W2 = {~W1[33:1], 1'b1};
    localparam vfd_word_t W3 = 34'h0f00ff00f;
    logic       clk_sys, resetn, autoMode, blankDrv, dimSel, testA, testB, osc, latchHold;
    logic       serialClk, serialDataIn, hostStrobe, dataOutPinOut, dataOutPinOe_n;
    logic       blankPinOut, blankPinOe_n, loadBusy, doDrv;
    vfd_step_t  step;
    vfd_latch_t drvOut;
    int         fails, totalChecks;
    wire logic  doPin    = dataOutPinOe_n ? doDrv : dataOutPinOut;
    wire logic  blankPin = blankPinOe_n ? blankDrv : blankPinOut;
    wire logic  loadPin  = autoMode ? doPin : hostStrobe;
    always #50 clk_sys = ~clk_sys;
    always #200 osc = ~osc;
    vfd_host_model u_host (.serialClk(serialClk), .serialDataIn(serialDataIn),
        .loadStrobe(hostStrobe));
    vfd_driver u_dut (.clk_sys(clk_sys), .resetn(resetn), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .loadStrobe(loadPin), .dataOutPinIn(doPin),
        .dataOutPinOut(dataOutPinOut), .dataOutPinOe_n(dataOutPinOe_n),
        .blankPinIn(blankPin), .blankPinOut(blankPinOut), .blankPinOe_n(blankPinOe_n),
        .dimSourceSelect(dimSel), .dimLevelVoltage(step), .factoryTestSelA(testA),
        .factoryTestSelB(testB), .rcOscillatorPin(osc), .latchHold(latchHold),
        .drvOut(drvOut), .loadBusy(loadBusy));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic vfd_latch_t expOut(input vfd_word_t w);
        vfd_latch_t r;
        for (int n = 0; n < NUM_OUT; n++)
            r[n] = w[MAP[n]];
        return r;
    endfunction
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitClk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // duty counted in system clocks over one whole frame
    task automatic pwmStep(input int s);
        int onc;
        int hi;
        int lit;
        onc = s <= 12 ? s + 12 : s <= 24 ? 2 * s : s <= 36 ? 4 * s - 48 : s <= 48 ? 8 * s - 192 : 208;
        hi = 0;
        lit = 0;
        step = 6'(s);
        waitClk(8200);
        repeat (8192)
        begin
            @(negedge clk_sys);
            hi += int'(blankPinOut === 1'b1);
            lit += int'(drvOut === expOut(W3));
        end
        check("pwm high", 33'(hi), 33'(4 * onc));
        check("lit", 33'(lit), 33'(4 * onc));
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        clk_sys = 1'b0;
        osc = 1'b0;
        resetn = 1'b0;
        {autoMode, dimSel, testA, testB, latchHold, doDrv} = 6'h00;
        blankDrv = 1'b1;
        step = 6'h00;
        fails = 0;
        totalChecks = 0;
        waitClk(2);
        resetn = 1'b1;
        waitClk(6);
        check("drvOut", drvOut, 33'h0);
        check("blank oe", 33'(blankPinOe_n), 33'h1);
        check("data oe", 33'(dataOutPinOe_n), 33'h0);
        $display("test reset done");
        u_host.sendWord(W1);
        waitClk(4);
        check("serial out", 33'(dataOutPinOut), 33'(W1[0]));
        u_host.pulseLoad();
        check("serial out", 33'(dataOutPinOut), 33'h0);
        check("drvOut", drvOut, expOut(W1));
        blankDrv = 1'b0;
        waitClk(8);
        check("drvOut", drvOut, 33'h0);
        blankDrv = 1'b1;
        $display("test direct load done");
        u_host.holdLoad(1'b1);
        u_host.sendWord(W2);
        u_host.holdLoad(1'b0);
        waitClk(8);
        check("serial out", 33'(dataOutPinOut), 33'h0);
        u_host.pulseLoad();
        check("drvOut", drvOut, 33'h0);
        $display("test strobe high done");
        autoMode = 1'b1;
        u_host.sendWord(W2);
        waitClk(20);
        check("drvOut", drvOut, expOut(W2));
        check("serial out", 33'(dataOutPinOut), 33'h0);
        autoMode = 1'b0;
        $display("test auto load done");
        latchHold = 1'b1;
        u_host.sendWord(W1);
        u_host.pulseLoad();
        u_host.sendWord(W2);
        u_host.pulseLoad();
        u_host.sendWord(W3);
        u_host.pulseLoad();
        check("busy", 33'(loadBusy), 33'h1);
        check("drvOut", drvOut, expOut(W2));
        latchHold = 1'b0;
        for (n = 0; n < 40 && loadBusy !== 1'b0; n++)
            waitClk(1);
        if (n == 40)
        begin
            fails++;
            give_verdict();
        end
        waitClk(6);
        check("drvOut", drvOut, expOut(W3));
        $display("test buffer done");
        for (n = 0; n < 3; n++)
        begin
            testA = 1'(n == 0);
            testB = 1'(n == 1);
            waitClk(8);
            check("data oe", 33'(dataOutPinOe_n), 33'(n < 2));
            check("blank oe", 33'(blankPinOe_n), 33'(n == 2));
        end
        // test mode shifts from the serial output pin, not the data pin
        testA = 1'b1;
        doDrv = 1'b1;
        waitClk(8);
        u_host.sendWord(~W3);
        testA = 1'b0;
        doDrv = 1'b0;
        waitClk(8);
        check("serial out", 33'(dataOutPinOut), 33'h1);
        $display("test mode done");
        dimSel = 1'b1;
        waitClk(8);
        check("blank oe", 33'(blankPinOe_n), 33'h0);
        foreach (STEPS[i])
            pwmStep(STEPS[i]);
        $display("test dimming done");
        give_verdict();
    end
    initial
    begin
        #10ms;
        fails++;
        give_verdict();
    end
endmodule
